// ===== logic/mas_pkg.sv
// constants and types shared by the converter end and the controller end
// Overview of operation
// - chip-select rising edge starts a conversion
// - controller gives at most 31 clocks per read
// - 32nd falling serial clock autostarts a conversion
// - serial clock rate and placement are free
// - simultaneous mode drives one common chip-select
// - common chip-select converters start and finish together
// - interleaved mode gives each converter own chip-select
// - chip-select rises spread evenly over one period
// - four interleaved converters give four times rate
// - serial clock shared, chip-select picks the converter
// - external serial clock, single shortened read cycles
// - one shared oscillator feeds every notch select input
// - each result settles within its own conversion
// - modulator sample rate is oscillator over ten
// - chip-select high floats data and starts conversion
// - data low marks end of conversion; controller waits
package mas_pkg;
    localparam int N_CONV = 4;           // converters in the group
    localparam int RES_W = 32;           // full result word
    localparam int READ_BITS = 31;       // shortened read length
    localparam int ANALOG_W = 30;        // analog stand-in width
    localparam int FS_DIV = 10;          // oscillator cycles per sample
    localparam int CONV_SAMPLES = 2048;  // samples per conversion
    localparam int NOTCH_HZ = 60;        // notch of the default timing
    localparam int OSC_DIV = 8;          // mclk cycles per oscillator cycle
    localparam int SCK_HALF = 64;        // mclk cycles per serial clock half
    localparam int CS_HIGH_CYC = 64;     // least chip-select high time
    localparam int READ_MARGIN = 4096;   // mclk cycles kept for one read
    // one conversion in mclk cycles plus margin, shared out over the slots
    localparam int CONV_MCLK = CONV_SAMPLES * FS_DIV * OSC_DIV;
    localparam int SLOT_CYC = (CONV_MCLK + READ_MARGIN) / N_CONV;

    typedef enum logic [0:0] {
        MAS_CONV = 1'h0,
        MAS_READY = 1'h1
    } mas_dev_state_t;

    typedef enum logic [1:0] {
        MAS_HOLD = 2'h0,
        MAS_GAP = 2'h1,
        MAS_EOC = 2'h2,
        MAS_READ = 2'h3
    } mas_host_state_t;
endpackage : mas_pkg

// ===== logic/mas_link_if.sv
// serial link between the controller and the converter group
`timescale 1ns/100ps
interface mas_link_if #(parameter int N = mas_pkg::N_CONV);
    wire osc_clk;          // shared conversion oscillator, link clock
    wire sck;              // shared serial clock
    wire [N-1:0] cs_n;     // chip-select per converter
    wire [N-1:0] sdo_o;    // data driven by each converter
    wire [N-1:0] sdo_oe;   // high while that converter drives
    wire [N-1:0] sdo;      // resolved data lines, pulled up when free

    // undriven lines float high through the pull-up
    assign sdo = (sdo_o & sdo_oe) | ~sdo_oe;

    modport conv (input osc_clk, input sck, input cs_n, output sdo_o, output sdo_oe);
    modport host (output osc_clk, output sck, output cs_n, input sdo);
endinterface : mas_link_if

// ===== logic/mas_conv_end.sv
// converter end: conversion timing, end-of-conversion flag and result shifter
`timescale 1ns/100ps
module mas_conv_end #(
    parameter int IDX = 0,
    parameter int CONV_SAMPLES = mas_pkg::CONV_SAMPLES
) (
    mas_link_if.conv lnk,
    input wire logic sys_rst_i,
    input wire logic [mas_pkg::ANALOG_W-1:0] ain_i,
    output logic busy_o
);
    initial begin
        if (CONV_SAMPLES < 2 || CONV_SAMPLES > 65536 || IDX < 0) begin
            $error("mas_conv_end: parameter out of range");
        end
    end

    logic rst_s1, rst_s2;
    logic cs_s1, cs_s2, cs_d;
    logic sck_s1, sck_s2, sck_d;
    logic [mas_pkg::ANALOG_W-1:0] ain_s1, ain_s2;
    mas_pkg::mas_dev_state_t state_r;
    logic [3:0] div_r;
    logic [15:0] smp_r;
    logic [4:0] bit_r;
    logic [mas_pkg::RES_W-1:0] word_r;
    logic sdo_r, oe_r;

    // synchronisers into the oscillator domain
    always_ff @(posedge lnk.osc_clk) begin
        rst_s1 <= sys_rst_i;
        rst_s2 <= rst_s1;
        cs_s1 <= lnk.cs_n[IDX];
        cs_s2 <= cs_s1;
        cs_d <= cs_s2;
        sck_s1 <= lnk.sck;
        sck_s2 <= sck_s1;
        sck_d <= sck_s2;
        ain_s1 <= ain_i;
        ain_s2 <= ain_s1;
    end

    // edge and tick decode
    wire cs_rise = cs_s2 & ~cs_d;
    wire cs_low = ~cs_s2;
    wire sck_fall = sck_d & ~sck_s2;
    wire fs_tick = div_r == 4'(mas_pkg::FS_DIV - 1);
    wire last_smp = smp_r == 16'(CONV_SAMPLES - 1);
    wire auto_go = (state_r == mas_pkg::MAS_READY) & cs_low & sck_fall
        & (bit_r == 5'(mas_pkg::RES_W - 1));
    wire go = cs_rise | auto_go;

    // conversion sequencing and result shifting
    always_ff @(posedge lnk.osc_clk) begin
        if (rst_s2) begin
            state_r <= mas_pkg::MAS_CONV;
            div_r <= 4'h0;
            smp_r <= 16'h0000;
            bit_r <= 5'h00;
            word_r <= '0;
        end else if (go) begin
            state_r <= mas_pkg::MAS_CONV;
            div_r <= 4'h0;
            smp_r <= 16'h0000;
            bit_r <= 5'h00;
        end else if (state_r == mas_pkg::MAS_CONV) begin
            div_r <= fs_tick ? 4'h0 : div_r + 4'h1;
            if (fs_tick && last_smp) begin
                state_r <= mas_pkg::MAS_READY;
                word_r <= {2'b00, ain_s2};                 // fresh sample only
            end else if (fs_tick) begin
                smp_r <= smp_r + 16'h0001;
            end
        end else if (cs_low && sck_fall) begin
            word_r <= {word_r[mas_pkg::RES_W-2:0], 1'b0};
            bit_r <= bit_r + 5'h01;
        end
    end

    // data pin: busy high, then word msb which is zero at end of conversion
    always_ff @(posedge lnk.osc_clk) begin
        if (rst_s2) begin
            sdo_r <= 1'b1;
            oe_r <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            sdo_r <= (state_r == mas_pkg::MAS_CONV) ? 1'b1 : word_r[mas_pkg::RES_W-1];
            oe_r <= cs_low;
            busy_o <= state_r == mas_pkg::MAS_CONV;
        end
    end

    assign lnk.sdo_o[IDX] = sdo_r;
    assign lnk.sdo_oe[IDX] = oe_r;
endmodule : mas_conv_end

// ===== logic/mas_host_end.sv
// controller end: oscillator, chip-select schedule and shortened reads
`timescale 1ns/100ps
module mas_host_end #(
    parameter int N = mas_pkg::N_CONV,
    parameter int SLOT_CYC = mas_pkg::SLOT_CYC,
    parameter int OSC_DIV = mas_pkg::OSC_DIV,
    parameter int SCK_HALF = mas_pkg::SCK_HALF,
    parameter int CS_HIGH_CYC = mas_pkg::CS_HIGH_CYC
) (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic interleave_i,
    mas_link_if.host lnk,
    output logic [N-1:0][mas_pkg::READ_BITS-1:0] res_data_o,
    output logic [N-1:0] res_mask_o,
    output logic res_valid_o,
    output logic res_miss_o
);
    localparam int SW = (N > 1) ? $clog2(N) : 1;
    localparam int RB = mas_pkg::READ_BITS;

    initial begin
        if (N < 2 || (N & (N - 1)) != 0 || OSC_DIV < 2 || OSC_DIV % 2 != 0
                || SCK_HALF < 16 || SCK_HALF > 65535 || CS_HIGH_CYC < 16
                || CS_HIGH_CYC > 65535 || SCK_HALF < 4 * OSC_DIV + 4 // data lags sck fall
                || CS_HIGH_CYC < 4 * OSC_DIV + 4                    // stale data must clear
                || SLOT_CYC < 2 * SCK_HALF * (RB + 1) + CS_HIGH_CYC) begin
            $error("mas_host_end: parameter out of range");
        end
    end

    // one-hot select of a slot's converter
    function automatic logic [N-1:0] slot_sel(input logic [SW-1:0] s);
        logic [N-1:0] m;
        m = '0;
        m[s] = 1'b1;
        return m;
    endfunction : slot_sel

    logic [15:0] odiv_r;
    logic osc_r;
    logic [31:0] cnt_r;
    logic [SW-1:0] slot_r;
    logic [N-1:0] sdo_s1, sdo_s2;
    mas_pkg::mas_host_state_t state_r;
    logic [N-1:0] cs_n_r, tgt_r;
    logic [15:0] gc_r, hc_r;
    logic [4:0] bc_r;
    logic sck_r;
    logic [N-1:0][RB-1:0] sh_r;

    // oscillator from mclk, common to every converter
    wire odiv_end = odiv_r == 16'(OSC_DIV / 2 - 1);
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            odiv_r <= 16'h0000;
            osc_r <= 1'b0;
        end else begin
            odiv_r <= odiv_end ? 16'h0000 : odiv_r + 16'h0001;
            osc_r <= odiv_end ? ~osc_r : osc_r;
        end
    end

    // returning data lines from the oscillator domain
    always_ff @(posedge mclk_i) begin
        sdo_s1 <= lnk.sdo;
        sdo_s2 <= sdo_s1;
    end

    // slot timer: N evenly spaced launch instants per conversion period
    wire tick = cnt_r == 32'(SLOT_CYC - 1);
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_r <= 32'h00000000;
            slot_r <= '0;
        end else begin
            cnt_r <= tick ? 32'h00000000 : cnt_r + 32'h00000001;
            slot_r <= tick ? slot_r + SW'(1) : slot_r;
        end
    end

    // launch decode: every slot interleaved, once per period simultaneous
    wire act = tick & (interleave_i | slot_r == SW'(N - 1));
    wire [N-1:0] next_tgt = interleave_i ? slot_sel(slot_r + SW'(2)) : {N{1'b1}};
    wire eoc = (sdo_s2 & tgt_r) == '0;
    wire half_end = hc_r == 16'(SCK_HALF - 1);
    wire gap_end = gc_r == 16'(CS_HIGH_CYC - 1);
    wire last_bit = bc_r == 5'(RB - 1);
    wire busy_st = state_r == mas_pkg::MAS_EOC || state_r == mas_pkg::MAS_READ;

    // chip-select and serial clock sequencing
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_r <= mas_pkg::MAS_HOLD;
            cs_n_r <= '1;
            tgt_r <= '0;
            gc_r <= 16'h0000;
            hc_r <= 16'h0000;
            bc_r <= 5'h00;
            sck_r <= 1'b0;
        end else if (act) begin
            cs_n_r <= '1;
            sck_r <= 1'b0;
            tgt_r <= next_tgt;
            gc_r <= 16'h0000;
            state_r <= mas_pkg::MAS_GAP;
        end else begin
            case (state_r)
                mas_pkg::MAS_GAP: begin
                    gc_r <= gc_r + 16'h0001;
                    if (gap_end) begin
                        cs_n_r <= ~tgt_r;
                        state_r <= mas_pkg::MAS_EOC;
                    end
                end
                mas_pkg::MAS_EOC: begin
                    hc_r <= 16'h0000;
                    bc_r <= 5'h00;
                    if (eoc) begin
                        state_r <= mas_pkg::MAS_READ;
                    end
                end
                mas_pkg::MAS_READ: begin
                    hc_r <= half_end ? 16'h0000 : hc_r + 16'h0001;
                    if (half_end) begin
                        sck_r <= ~sck_r;
                    end
                    if (half_end && sck_r) begin
                        bc_r <= bc_r + 5'h01;
                    end
                    if (half_end && sck_r && last_bit) begin
                        state_r <= mas_pkg::MAS_HOLD;      // stop at 31
                    end
                end
                default: begin
                    state_r <= mas_pkg::MAS_HOLD;
                end
            endcase
        end
    end

    // sample every line on the rising serial clock
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sh_r <= '0;
        end else if (state_r == mas_pkg::MAS_READ && half_end && !sck_r && !act) begin
            for (int i = 0; i < N; i++) begin
                sh_r[i] <= {sh_r[i][RB-2:0], sdo_s2[i]};
            end
        end
    end

    // result hand-off and missed-read flag
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            res_data_o <= '0;
            res_mask_o <= '0;
            res_valid_o <= 1'b0;
            res_miss_o <= 1'b0;
        end else begin
            res_valid_o <= 1'b0;
            res_miss_o <= act & busy_st;
            if (!act && state_r == mas_pkg::MAS_READ && half_end && sck_r && last_bit) begin
                res_data_o <= sh_r;
                res_mask_o <= tgt_r;
                res_valid_o <= 1'b1;
            end
        end
    end

    assign lnk.osc_clk = osc_r;
    assign lnk.sck = sck_r;
    assign lnk.cs_n = cs_n_r;
endmodule : mas_host_end

// ===== tb/mas_link_monitor.sv
// link checker: chip-select, serial clock, oscillator and data drive relations
`timescale 1ns/100ps
module mas_monitor (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire osc_clk,
    input wire sck,
    input wire [mas_pkg::N_CONV-1:0] cs_n,
    input wire [mas_pkg::N_CONV-1:0] sdo_oe,
    input wire [mas_pkg::N_CONV-1:0] sdo
);
    logic sck_r;
    logic [5:0] fall_cnt_r;
    logic [5:0] fall_cnt_nxt;

    // falling serial clock edges since the chip-selects were last all high
    assign fall_cnt_nxt = (&cs_n) ? 6'h0 : fall_cnt_r + {5'h0, sck_r & ~sck};
    always_ff @(posedge mclk_i) begin
        sck_r <= sys_rst_i ? 1'h0 : sck;
        fall_cnt_r <= sys_rst_i ? 6'h0 : fall_cnt_nxt;
    end

    // all chip-selects released at a tick
    sequence s_release;
        $rose(&cs_n);
    endsequence

    AST_CS_HIGH_TIME: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_release |-> (&cs_n) [*8]) else $error("chip-select high time too short");
    AST_FLOAT: assert property (@(posedge osc_clk) disable iff (sys_rst_i)
        (&cs_n) [*6] |-> !(|sdo_oe)) else $error("data driven while deselected");
    AST_DRIVE: assert property (@(posedge osc_clk) disable iff (sys_rst_i)
        (!cs_n[0]) [*6] |-> sdo_oe[0]) else $error("data not driven while selected");
    AST_SCK_MAX: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        fall_cnt_r <= 6'h1F) else $error("more than 31 serial clocks in a read");
    AST_FULL_READ: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_release |-> (fall_cnt_r == 6'h0 || fall_cnt_r == 6'h1F))
        else $error("release after a partial read");
    AST_EOC_FIRST: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(sck) && fall_cnt_r == 6'h0 |-> !(|(~cs_n & sdo)))
        else $error("clocking before end of conversion");
    AST_SCK_IDLE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (&cs_n) |-> !sck) else $error("serial clock high with nothing selected");
    AST_OSC: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(osc_clk) |-> osc_clk [*4] ##1 !osc_clk) else $error("oscillator period wrong");
endmodule : mas_monitor

// ===== tb/multi_adc_sync_control_test.sv
// bench: controller and four converters in simultaneous and interleaved modes
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module multi_adc_sync_control_test;
    localparam int N = mas_pkg::N_CONV;
    localparam int SLOT_N = 2704; // whole oscillator periods keep spacing exact
    logic mclk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic dev_rst = 1'h1;
    logic interleave_i = 1'h0;
    logic [mas_pkg::ANALOG_W-1:0] ain [N];
    wire logic [N-1:0] busy;
    logic [N-1:0][mas_pkg::READ_BITS-1:0] res_data;
    logic [N-1:0] res_mask;
    logic [N-1:0] prev_mask;
    logic res_valid;
    logic res_miss;
    logic armed = 1'h0;
    logic miss_seen = 1'h0;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    int last_t = 0;

    mas_link_if lnk ();
    mas_host_end #(.SLOT_CYC(SLOT_N), .SCK_HALF(40), .CS_HIGH_CYC(64)) i_mas_host_end (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .interleave_i(interleave_i), .lnk(lnk.host),
        .res_data_o(res_data), .res_mask_o(res_mask), .res_valid_o(res_valid),
        .res_miss_o(res_miss));
    for (genvar g = 0; g < N; g++) begin : gen_conv
        mas_conv_end #(.IDX(g), .CONV_SAMPLES(16)) i_mas_conv_end (
            .lnk(lnk.conv), .sys_rst_i(dev_rst), .ain_i(ain[g]), .busy_o(busy[g]));
    end
    mas_monitor i_mas_monitor (.mclk_i(mclk_i), .sys_rst_i(dev_rst), .osc_clk(lnk.osc_clk),
        .sck(lnk.sck), .cs_n(lnk.cs_n), .sdo_oe(lnk.sdo_oe), .sdo(lnk.sdo));

    // clock
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    // cycle ceiling and watch for aborted reads
    always @(posedge mclk_i) begin
        cycles++;
        if (armed && res_miss === 1'h1) miss_seen = 1'h1;
        if (cycles == 99000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // host reset first, converters kept in reset while the oscillator runs
    task automatic restart(input logic mode);
        sys_rst_i = 1'h1;
        dev_rst = 1'h1;
        interleave_i = mode;
        armed = 1'h0;
        repeat (10) @(negedge mclk_i);
        sys_rst_i = 1'h0;
        repeat (50) @(negedge mclk_i);
        dev_rst = 1'h0;
    endtask : restart

    // collect n results and check data, mask, spacing and, in simultaneous mode, converter state
    task automatic run(input logic mode, input int n);
        int w;
        restart(mode);
        for (int k = 0; k < n; k++) begin
            w = 0;
            do begin
                @(negedge mclk_i);
                w++;
            end while (res_valid !== 1'h1 && w < 30000);
            for (int i = 0; i < N; i++) begin
                if (res_mask[i] === 1'h1) `CHK(res_data[i], {2'h0, ain[i][29:1]})
            end
            if (mode) begin
                `CHK($countones(res_mask), 1)
                if (k > 0) `CHK(res_mask, {prev_mask[N-2:0], prev_mask[N-1]})
            end else begin
                `CHK(res_mask, 4'hF)
                `CHK(busy, 4'h0)
            end
            // first simultaneous read finds the power-on result without waiting
            if (k > (mode ? 0 : 1)) `CHK(cycles - last_t, mode ? SLOT_N : N * SLOT_N)
            last_t = cycles;
            prev_mask = res_mask;
            armed = 1'h1;
            // fresh inputs while idle: next result must show no history
            if (!mode && k == 2) begin
                for (int i = 0; i < N; i++) ain[i] = ain[i] ^ 30'h2AAAAAAA;
            end
        end
    endtask : run

    // main sequence
    initial begin
        for (int i = 0; i < N; i++) ain[i] = 30'(32'h01234567 * (i + 1));
        run(1'h0, 6);
        run(1'h1, 9);
        `CHK(miss_seen, 1'h0)
        close_out();
    end
endmodule : multi_adc_sync_control_test
